// ### dv/pio_pin_model.sv
/*
 * Behavioural model of the circuitry at the pins of one port: switches that
 * may drive each pin, the internal pull-ups and a floating line otherwise.
 * It assumes the block's out, oe and pullup outputs for that port.
 */
`timescale 1ns/1ps

module pio_pin_model #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] out,
   input  wire logic [W-1:0] oe,
   input  wire logic [W-1:0] pull_en,
   input  wire logic [W-1:0] ext_en,
   input  wire logic [W-1:0] ext_val,
   output logic [W-1:0]      pin
);
   logic [W-1:0] flt_q = '0;

   // An undriven line toggles so that a stale value never passes for a real one.
   always_ff @(posedge clk) flt_q <= ~flt_q;

   // The block's driver wins, then a switch, then the pull-up.
   always_comb begin
      for (int i = 0; i < W; i++) begin
         pin[i] = oe[i] ? out[i] : ext_en[i] ? ext_val[i] : pull_en[i] ? 1'b1 : flt_q[i];
      end
   end
endmodule

// ### dv/tb_pio_port.sv
/*
 * Self-checking testbench for the three-port I/O block.
 * It assumes the block answers reads one cycle after the strobe.
 */
`timescale 1ns/1ps

module tb_pio_port;
   import pio_pkg::*;
   logic clk = 0, rst_b = 0, lv_rst = 0, wd_tmo = 0, halt = 0;
   pio_mem_req_t req = '0;
   logic [7:0] rdata, ext_en[3] = '{default: 8'h00}, ext_val[3] = '{default: 8'h00};
   logic rvalid, low_power, wake;
   logic [7:0] a_out, a_oe, a_pu, a_pin;
   logic [6:0] b_out, b_oe, b_pu, b_pin;
   logic [2:0] c_out, c_oe, c_pu, c_pin, sel_pins;
   int error_cnt = 0, tests_run = 0, cyc = 0;

   always #5 clk = ~clk;

   pio_port DUT (.clk(clk), .rst_b(rst_b), .mem_req(req), .mem_rdata(rdata),
      .mem_rvalid(rvalid), .low_voltage_reset(lv_rst), .watchdog_timeout(wd_tmo),
      .halt_exec(halt), .low_power(low_power), .wake(wake), .first_port_in(a_pin),
      .first_port_out(a_out), .first_port_oe(a_oe), .first_port_pullup(a_pu),
      .second_port_in(b_pin), .second_port_out(b_out), .second_port_oe(b_oe),
      .second_port_pullup(b_pu), .third_port_in(c_pin), .third_port_out(c_out),
      .third_port_oe(c_oe), .third_port_pullup(c_pu),
      .interface_function_select(sel_pins));
   pio_pin_model #(.W(8)) pm_a (.clk(clk), .out(a_out), .oe(a_oe), .pull_en(a_pu),
      .ext_en(ext_en[0]), .ext_val(ext_val[0]), .pin(a_pin));
   pio_pin_model #(.W(7)) pm_b (.clk(clk), .out(b_out), .oe(b_oe), .pull_en(b_pu),
      .ext_en(ext_en[1][6:0]), .ext_val(ext_val[1][6:0]), .pin(b_pin));
   pio_pin_model #(.W(3)) pm_c (.clk(clk), .out(c_out), .oe(c_oe), .pull_en(c_pu),
      .ext_en(ext_en[2][2:0]), .ext_val(ext_val[2][2:0]), .pin(c_pin));

   task automatic final_report();
      $display("tests %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // A hung wait must not stall the run forever.
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         error_cnt++;
         final_report();
      end
   end

   // Inputs always move 1 ns after the rising edge.
   task automatic step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask

   // An idle cycle follows each access so a strobe is never reassigned at once.
   task automatic wr(logic [7:0] a, logic [7:0] d);
      req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      step(1);
      req = '0;
      step(1);
   endtask

   task automatic rdchk(logic [7:0] a, logic [7:0] exp, string name);
      req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      step(1);
      req = '0;
      chk("read valid", 8'h01, {7'h00, rvalid});
      chk(name, exp, rdata);
      step(1);
   endtask

   task automatic pulse_halt();
      halt = 1;
      step(1);
      halt = 0;
   endtask

   task automatic t_reset();
      chk("oe", 8'h00, a_oe | b_oe | c_oe);
      chk("latch a", 8'hFF, a_out);
      chk("latch c", 8'h07, {5'h00, c_out});
      rdchk(PIO_DIR_OFS[1], 8'h7F, "dir b");
      rdchk(PIO_DIR_OFS[2], 8'h07, "dir c");
      rdchk(PIO_PU_OFS[2], 8'h00, "pullup c");
      rdchk(PIO_WU_OFS, 8'h00, "wake enable");
      rdchk(PIO_SEL_OFS, 8'h00, "select");
      $display("test reset done");
   endtask

   task automatic t_output();
      ext_en[0] = 8'hFF;
      ext_val[0] = 8'hAA;
      wr(PIO_DATA_OFS[0], 8'h55);
      wr(PIO_DIR_OFS[0], 8'h00);
      chk("out a", 8'h55, a_out);
      chk("oe a", 8'hFF, a_oe);
      rdchk(PIO_DATA_OFS[0], 8'h55, "latch read");
      step(10);
      chk("held a", 8'h55, a_out);
      wr(PIO_DIR_OFS[1], 8'hFF);
      rdchk(PIO_DIR_OFS[1], 8'h7F, "masked dir b");
      wr(8'h0F, 8'hFF);
      rdchk(8'h0F, 8'h00, "unmapped");
      wr(PIO_SEL_OFS, 8'hFF);
      rdchk(PIO_SEL_OFS, 8'h07, "select");
      chk("select pins", 8'h07, {5'h00, sel_pins});
      $display("test output done");
   endtask

   task automatic t_input();
      wr(PIO_DIR_OFS[0], 8'hFF);
      ext_en[2] = 8'h07;
      ext_val[2] = 8'h05;
      step(3);
      rdchk(PIO_DATA_OFS[0], 8'hAA, "pin a");
      rdchk(PIO_DATA_OFS[2], 8'h05, "pin c");
      $display("test input done");
   endtask

   task automatic t_pullup();
      wr(PIO_PU_OFS[1], 8'hFF);
      step(1);
      chk("pullup b", 8'h7F, {1'b0, b_pu});
      rdchk(PIO_PU_OFS[1], 8'h7F, "pullup reg b");
      rdchk(PIO_DATA_OFS[1], 8'h7F, "pulled pins b");
      chk("pullup a", 8'h00, a_pu);
      wr(PIO_DIR_OFS[1], 8'h00);
      step(1);
      chk("pullup out b", 8'h00, {1'b0, b_pu});
      chk("oe b", 8'h7F, {1'b0, b_oe});
      wr(PIO_DATA_OFS[1], 8'hAA);
      chk("out b", 8'h2A, {1'b0, b_out});
      $display("test pullup done");
   endtask

   task automatic t_wake();
      logic seen;
      seen = 0;
      ext_val[0] = 8'hFF;
      wr(PIO_WU_OFS, 8'h01);
      rdchk(PIO_WU_OFS, 8'h01, "wake enable");
      pulse_halt();
      chk("sleep", 8'h01, {7'h00, low_power});
      ext_val[0] = 8'hFD;
      step(8);
      chk("no wake", 8'h02, {6'h00, low_power, wake});
      ext_val[0] = 8'hFC;
      for (int i = 0; i < 8; i++) begin
         step(1);
         seen = seen | wake;
      end
      chk("wake", 8'h01, {7'h00, seen});
      chk("awake", 8'h00, {7'h00, low_power});
      $display("test wake done");
   endtask

   task automatic t_resets();
      wr(PIO_DATA_OFS[2], 8'h00);
      wr(PIO_DIR_OFS[2], 8'h00);
      wr(PIO_PU_OFS[2], 8'h07);
      chk("pullup c out", 8'h00, {5'h00, c_pu});
      pulse_halt();
      wd_tmo = 1;
      step(1);
      wd_tmo = 0;
      step(2);
      chk("sleep watchdog out", 8'h00, {5'h00, c_out});
      chk("sleep watchdog oe", 8'h07, {5'h00, c_oe});
      chk("watchdog exit", 8'h00, {7'h00, low_power});
      wd_tmo = 1;
      step(1);
      wd_tmo = 0;
      step(2);
      chk("watchdog out", 8'h07, {5'h00, c_out});
      chk("watchdog oe", 8'h00, {5'h00, c_oe});
      wr(PIO_DATA_OFS[2], 8'h00);
      wr(PIO_PU_OFS[2], 8'h07);
      chk("pullup c in", 8'h07, {5'h00, c_pu});
      wr(PIO_DIR_OFS[2], 8'h00);
      lv_rst = 1;
      step(1);
      lv_rst = 0;
      step(2);
      chk("low voltage out", 8'h07, {5'h00, c_out});
      chk("low voltage oe", 8'h00, {5'h00, c_oe});
      chk("low voltage pullup", 8'h00, {5'h00, c_pu});
      rdchk(PIO_PU_OFS[2], 8'h00, "low voltage pullup reg");
      $display("test resets done");
   endtask

   initial begin
      step(6);
      rst_b = 1;
      step(1);
      t_reset();
      t_output();
      t_input();
      t_pullup();
      t_wake();
      t_resets();
      final_report();
   end
endmodule

// ### hdl/pio_pkg.sv
/*
 * Package for the three-port general-purpose I/O block. It holds the register
 * offsets, the implemented-bit masks, the reset values and the carrier type of
 * the data-memory access port.
 * It assumes an 8-bit data-memory address space driven by the processor core.
 */
package pio_pkg;

   // Port count and width of the per-port register arrays.
   localparam int PIO_NPORT = 3;
   localparam int PIO_W     = 8;

   // Register offsets inside the data-memory space, ordered {third, second, first}.
   localparam logic [2:0][7:0] PIO_DATA_OFS = {8'h08, 8'h04, 8'h00};
   localparam logic [2:0][7:0] PIO_DIR_OFS  = {8'h09, 8'h05, 8'h01};
   localparam logic [2:0][7:0] PIO_PU_OFS   = {8'h0A, 8'h06, 8'h02};
   localparam logic [7:0]      PIO_WU_OFS   = 8'h03;
   localparam logic [7:0]      PIO_SEL_OFS  = 8'h0B;

   // Implemented bits of each port; the rest read as zero.
   localparam logic [2:0][7:0] PIO_MASK     = {8'h07, 8'h7F, 8'hFF};
   localparam logic [7:0]      PIO_SEL_MASK = 8'h07;

   // Reset values: pins come up as inputs with the latches high and pull-ups off.
   localparam logic [2:0][7:0] PIO_DATA_RST = {8'h07, 8'h7F, 8'hFF};
   localparam logic [2:0][7:0] PIO_DIR_RST  = {8'h07, 8'h7F, 8'hFF};
   localparam logic [7:0]      PIO_PU_RST   = 8'h00;
   localparam logic [7:0]      PIO_WU_RST   = 8'h00;
   localparam logic [7:0]      PIO_SEL_RST  = 8'h00;

   // Direction encoding: one makes the pin an input.
   localparam logic PIO_DIR_IN = 1'b1;

   // One access from the core to the data-memory space.
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pio_mem_req_t;

endpackage

// ### hdl/pio_port.sv
/*
 * Three-port bidirectional I/O block with data latches, direction control,
 * per-pin pull-up enables and falling-edge wake-up on the first port.
 * It assumes the core presents one data-memory access per cycle on mem_req,
 * that low_voltage_reset, watchdog_timeout and halt pulses come from
 * logic on clk, and that pin inputs are asynchronous to clk.
 */
`timescale 1ns/1ps

module pio_port (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire pio_pkg::pio_mem_req_t mem_req,
   output logic [7:0]                 mem_rdata,
   output logic                       mem_rvalid,
   input  wire logic                  low_voltage_reset,
   input  wire logic                  watchdog_timeout,
   input  wire logic                  halt_exec,
   output logic                       low_power,
   output logic                       wake,
   input  wire logic [7:0]            first_port_in,
   output logic [7:0]                 first_port_out,
   output logic [7:0]                 first_port_oe,
   output logic [7:0]                 first_port_pullup,
   input  wire logic [6:0]            second_port_in,
   output logic [6:0]                 second_port_out,
   output logic [6:0]                 second_port_oe,
   output logic [6:0]                 second_port_pullup,
   input  wire logic [2:0]            third_port_in,
   output logic [2:0]                 third_port_out,
   output logic [2:0]                 third_port_oe,
   output logic [2:0]                 third_port_pullup,
   output logic [2:0]                 interface_function_select
);
   import pio_pkg::*;

   logic [2:0][7:0] data_q, data_d;
   logic [2:0][7:0] dir_q,  dir_d;
   logic [2:0][7:0] pu_q,   pu_d;
   logic [2:0][7:0] oe_q,   oe_d;
   logic [2:0][7:0] pun_q,  pun_d;
   logic [7:0]      wu_q,   wu_d;
   logic [7:0]      sel_q,  sel_d;
   logic [2:0][7:0] pin_raw;
   logic [2:0][7:0] sync1_q, sync2_q;
   logic [7:0]      prev_q;
   logic [7:0]      rdata_q, rdata_d;
   logic            rvalid_q, rvalid_d;
   logic            sleep_q, sleep_d;
   logic            wake_q, wake_d;
   logic            soft_rst;
   logic [7:0]      fall;

   // Unused pin positions are tied low so that they read as zero after masking.
   assign pin_raw = {5'h00, third_port_in, 1'b0, second_port_in, first_port_in};

   // A watchdog timeout while asleep keeps the port state; the others restore it.
   assign soft_rst = low_voltage_reset | (watchdog_timeout & ~sleep_q);

   // Two-stage synchroniser; only the second stage feeds any logic.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q[0];
      end
   end

   // Falling edges seen on the synchronised first port.
   assign fall = prev_q & ~sync2_q[0];

   // Register writes, soft resets and the pin-control copies.
   always_comb begin
      data_d = data_q;
      dir_d  = dir_q;
      pu_d   = pu_q;
      wu_d   = wu_q;
      sel_d  = sel_q;
      for (int p = 0; p < PIO_NPORT; p++) begin
         if (mem_req.wr && mem_req.addr == PIO_DATA_OFS[p]) begin
            data_d[p] = mem_req.wdata & PIO_MASK[p];
         end
         if (mem_req.wr && mem_req.addr == PIO_DIR_OFS[p]) begin
            dir_d[p] = mem_req.wdata & PIO_MASK[p];
         end
         if (mem_req.wr && mem_req.addr == PIO_PU_OFS[p]) begin
            pu_d[p] = mem_req.wdata & PIO_MASK[p];
         end
      end
      if (mem_req.wr && mem_req.addr == PIO_WU_OFS) begin
         wu_d = mem_req.wdata;
      end
      if (mem_req.wr && mem_req.addr == PIO_SEL_OFS) begin
         sel_d = mem_req.wdata & PIO_SEL_MASK;
      end
      if (soft_rst) begin
         data_d = PIO_DATA_RST;
         dir_d  = PIO_DIR_RST;
         for (int p = 0; p < PIO_NPORT; p++) begin
            pu_d[p] = PIO_PU_RST;
         end
         wu_d  = PIO_WU_RST;
         sel_d = PIO_SEL_RST;
      end
      // Output drivers and pull-ups follow the registers one cycle later.
      for (int p = 0; p < PIO_NPORT; p++) begin
         oe_d[p]  = ~dir_q[p] & PIO_MASK[p];
         pun_d[p] = pu_q[p] & dir_q[p];
      end
   end

   // Configuration registers.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_q <= PIO_DATA_RST;
         dir_q  <= PIO_DIR_RST;
         pu_q   <= '0;
         oe_q   <= '0;
         pun_q  <= '0;
         wu_q   <= PIO_WU_RST;
         sel_q  <= PIO_SEL_RST;
      end else begin
         data_q <= data_d;
         dir_q  <= dir_d;
         pu_q   <= pu_d;
         oe_q   <= oe_d;
         pun_q  <= pun_d;
         wu_q   <= wu_d;
         sel_q  <= sel_d;
      end
   end

   // Read path: input pins return the live sampled level, outputs the latch.
   always_comb begin
      rdata_d  = 8'h00; // Unmapped addresses read as zero.
      rvalid_d = mem_req.rd;
      if (mem_req.rd) begin
         for (int p = 0; p < PIO_NPORT; p++) begin
            if (mem_req.addr == PIO_DATA_OFS[p]) begin
               rdata_d = ((dir_q[p] & sync2_q[p]) | (~dir_q[p] & data_q[p]))
                         & PIO_MASK[p];
            end
            if (mem_req.addr == PIO_DIR_OFS[p]) begin
               rdata_d = dir_q[p];
            end
            if (mem_req.addr == PIO_PU_OFS[p]) begin
               rdata_d = pu_q[p];
            end
         end
         if (mem_req.addr == PIO_WU_OFS) begin
            rdata_d = wu_q;
         end
         if (mem_req.addr == PIO_SEL_OFS) begin
            rdata_d = sel_q;
         end
      end
   end

   // Low-power state: halt enters it, an enabled falling edge leaves it.
   always_comb begin
      sleep_d = sleep_q;
      wake_d  = 1'b0;
      if (sleep_q && (fall & wu_q) != 8'h00) begin
         sleep_d = 1'b0;
         wake_d  = 1'b1;
      end else if (sleep_q && watchdog_timeout) begin
         sleep_d = 1'b0; // The watchdog is another exit path.
      end else if (!sleep_q && halt_exec) begin
         sleep_d = 1'b1;
      end
      if (low_voltage_reset) begin
         sleep_d = 1'b0;
      end
   end

   // Read answer and power-state registers.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
         sleep_q  <= 1'b0;
         wake_q   <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
         sleep_q  <= sleep_d;
         wake_q   <= wake_d;
      end
   end

   assign mem_rdata                 = rdata_q;
   assign mem_rvalid                = rvalid_q;
   assign low_power                 = sleep_q;
   assign wake                      = wake_q;
   assign first_port_out            = data_q[0];
   assign first_port_oe             = oe_q[0];
   assign first_port_pullup         = pun_q[0];
   assign second_port_out           = data_q[1][6:0];
   assign second_port_oe            = oe_q[1][6:0];
   assign second_port_pullup        = pun_q[1][6:0];
   assign third_port_out            = data_q[2][2:0];
   assign third_port_oe             = oe_q[2][2:0];
   assign third_port_pullup         = pun_q[2][2:0];
   assign interface_function_select = sel_q[2:0];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_pullup_needs_input: assert property (
      (first_port_pullup & first_port_oe) == 8'h00)
      else $error("Pull-up active on a driven first-port pin.");

   a_latch_holds: assert property (
      !(mem_req.wr && mem_req.addr == PIO_DATA_OFS[0]) && !soft_rst
      |=> $stable(first_port_out))
      else $error("First-port latch changed without a write.");

   a_write_reaches_pin: assert property (
      mem_req.wr && mem_req.addr == PIO_DATA_OFS[1] && !soft_rst
      |=> second_port_out == $past(mem_req.wdata[6:0]))
      else $error("Second-port write did not reach its pins.");

   a_unimpl_zero: assert property (
      mem_req.rd && mem_req.addr == PIO_DATA_OFS[2] |=> mem_rdata[7:3] == 5'h00)
      else $error("Unimplemented third-port bits read nonzero.");

   a_output_reads_latch: assert property (
      mem_req.rd && mem_req.addr == PIO_DATA_OFS[0] && dir_q[0] == 8'h00
      |=> mem_rdata == $past(data_q[0]))
      else $error("Output-port read did not return the latch.");

   a_wake_on_fall: assert property (
      sleep_q && (fall & wu_q) != 8'h00 |=> wake && !low_power ##1 !wake)
      else $error("Enabled falling edge did not wake the device.");

   a_no_wake_masked: assert property (
      wu_q == 8'h00 |=> !wake)
      else $error("Wake with every wake-up enable clear.");

   a_halt_sleeps: assert property (
      !sleep_q && halt_exec && !low_voltage_reset |=> low_power)
      else $error("Halt did not enter low power.");

   a_third_reset: assert property (
      low_voltage_reset |=> third_port_out == 3'h7 ##1 third_port_pullup == 3'h0
      && third_port_oe == 3'h0)
      else $error("Third port not restored by low-voltage reset.");

   a_watchdog_sleep_keeps: assert property (
      watchdog_timeout && sleep_q && !low_voltage_reset
      |=> $stable(third_port_out) && $stable(first_port_out))
      else $error("Watchdog in sleep changed port latches.");

   // The awake watchdog must restore the third port just like a low-voltage reset.
   a_watchdog_awake_resets: assert property (
      watchdog_timeout && !sleep_q |=> third_port_out == 3'h7 ##1 third_port_oe == 3'h0)
      else $error("Third port not restored by an awake watchdog timeout.");

   // The core relies on an answer exactly one cycle after each read strobe.
   a_rvalid_after_read: assert property (
      mem_req.rd |=> mem_rvalid)
      else $error("Read strobe without a read answer.");

   a_idle_reads_zero: assert property (
      !mem_req.rd |=> !mem_rvalid && mem_rdata == 8'h00)
      else $error("Read answer without a read strobe.");

   // Input bits must come from the synchroniser, never from a stale latch.
   a_input_reads_pin: assert property (
      mem_req.rd && mem_req.addr == PIO_DATA_OFS[2] && dir_q[2] == 8'h07
      |=> mem_rdata == {5'h00, $past(sync2_q[2][2:0])})
      else $error("Input-port read did not return the pin level.");

   // With every pin an input, the pull-ups must mirror their enable register.
   a_pullup_from_reg: assert property (
      dir_q[1] == 8'h7F |=> second_port_pullup == $past(pu_q[1][6:0]))
      else $error("Second-port pull-ups differ from their enable register.");

   // A wake pulse while awake would restart a core that never slept.
   a_wake_only_asleep: assert property (
      !sleep_q |=> !wake)
      else $error("Wake pulse while not in low power.");

   a_oe_follows_dir: assert property (
      1'b1 |=> third_port_oe == ~$past(dir_q[2][2:0]))
      else $error("Third-port drivers do not follow the direction bits.");

endmodule
